// >>> src/hpdpc_map_if.sv
`timescale 1ns/1ps
`default_nettype none
interface hpdpc_map_if;
    logic [7:1] off_mask;
    logic [2:0] enabled_count;
    logic [2:0] logical_num [1:7];
    modport src (output off_mask, input enabled_count, input logical_num);
    modport calc (input off_mask, output enabled_count, output logical_num);
endinterface
`default_nettype wire

// >>> src/hpdpc_pkg.sv
// What this block does
// - self-powered mask bits 7..1 set disable matching port; clear leaves it available
// - bus-powered mask bits 7..1 set disable matching port; clear leaves it available
// - bit zero of both masks always reads zero
// - masks act only with remap enable zero; disabled ports never offered
// - any pattern of disabled ports is accepted
// - report enabled-port count and renumber active ports contiguously
// - internal default option takes disables from plus/minus strap pins
// - self-powered current limit byte is VBUS draw in 2 mA units
// - bus-powered current limit byte is VBUS draw in 2 mA units
// - remap enable one selects remap mode for numbering and disabling
// - compound setting one declares the hub part of a compound device
package hpdpc_pkg;
    localparam int HPDPC_PORTS = 7;
    localparam logic [7:0] HPDPC_OFF_SP_MASK = 8'h0a;
    localparam logic [7:0] HPDPC_OFF_BP_MASK = 8'h0b;
    localparam logic [7:0] HPDPC_OFF_SP_LIMIT = 8'h0c;
    localparam logic [7:0] HPDPC_OFF_BP_LIMIT = 8'h0d;
    localparam logic [7:0] HPDPC_OFF_CTRL = 8'h10;
    localparam logic [7:0] HPDPC_OFF_STATUS = 8'h14;
    localparam logic [7:0] HPDPC_MASK_RSVD = 8'hfe;
    localparam logic [7:0] HPDPC_RST_MASK = 8'h00;
    localparam logic [7:0] HPDPC_RST_LIMIT = 8'h32;
    localparam int HPDPC_CTRL_REMAP = 0;
    localparam int HPDPC_CTRL_COMPOUND = 1;
    localparam int HPDPC_CTRL_DEFCFG = 2;
    localparam int HPDPC_CTRL_SELFPWR = 3;
    localparam logic [1:0] HPDPC_RESP_OKAY = 2'b00;
    localparam logic [1:0] HPDPC_RESP_SLVERR = 2'b10;
    localparam int HPDPC_MA_PER_UNIT = 2;
    localparam int HPDPC_SP_LIMIT_MA = 100;
    typedef logic [2:0] hpdpc_num_t;
endpackage

// >>> src/hpdpc_port_map.sv
`timescale 1ns/1ps
`default_nettype none
module hpdpc_port_map
    import hpdpc_pkg::*;
(
    hpdpc_map_if.calc map // mask in, count and numbers out
);
    // running count of available ports gives contiguous numbering
    function automatic hpdpc_num_t count_below(input logic [7:1] m, input int p);
        hpdpc_num_t c;
        c = 3'h0;
        for (int i = 1; i <= HPDPC_PORTS; i++)
        begin
            if (i <= p && !m[i])
                c = c + 3'h1;
        end
        return c;
    endfunction

    assign map.enabled_count = count_below(map.off_mask, HPDPC_PORTS);
    for (genvar g = 1; g <= HPDPC_PORTS; g++)
    begin : g_num
        assign map.logical_num[g] = map.off_mask[g] ? 3'h0 : count_below(map.off_mask, g);
    end
endmodule
`default_nettype wire

// >>> src/hpdpc_top.sv
// Local design decision: register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
module hpdpc_top
    import hpdpc_pkg::*;
(
    input wire logic clock_in, // 20 MHz clock
    input wire logic arst_n_in, // async reset, active low
    input wire logic [7:0] s_axi_awaddr_in, // write address
    input wire logic s_axi_awvalid_in, // write address valid
    output logic s_axi_awready_out, // write address ready
    input wire logic [31:0] s_axi_wdata_in, // write data
    input wire logic [3:0] s_axi_wstrb_in, // write strobes
    input wire logic s_axi_wvalid_in, // write data valid
    output logic s_axi_wready_out, // write data ready
    output logic [1:0] s_axi_bresp_out, // write response
    output logic s_axi_bvalid_out, // write response valid
    input wire logic s_axi_bready_in, // write response ready
    input wire logic [7:0] s_axi_araddr_in, // read address
    input wire logic s_axi_arvalid_in, // read address valid
    output logic s_axi_arready_out, // read address ready
    output logic [31:0] s_axi_rdata_out, // read data
    output logic [1:0] s_axi_rresp_out, // read response
    output logic s_axi_rvalid_out, // read data valid
    input wire logic s_axi_rready_in, // read data ready
    input wire logic [7:1] port_off_strap_plus_in, // dp strap pins
    input wire logic [7:1] port_off_strap_minus_in, // dm strap pins
    output logic [7:1] port_disabled_out, // ports withheld from host
    output logic [2:0] port_count_out, // enabled ports reported
    output logic [20:0] port_number_out, // 3-bit logical number per port
    output logic remap_mode_out, // remap mode active
    output logic compound_out, // declare compound device
    output logic [7:0] current_limit_out, // active limit, 2 mA units
    output logic [9:0] current_ma_out // active limit in mA
);
    // ************************************************************
    // strap synchronisers
    // ************************************************************
    logic [13:0] strap_meta_reg;
    logic [13:0] strap_sync_reg;
    always_ff @(posedge clock_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            strap_meta_reg <= 14'h0000;
            strap_sync_reg <= 14'h0000;
        end
        else
        begin
            strap_meta_reg <= {port_off_strap_plus_in, port_off_strap_minus_in};
            strap_sync_reg <= strap_meta_reg;
        end
    end
    wire [7:1] strap_off = strap_sync_reg[13:7] | strap_sync_reg[6:0];

    // ************************************************************
    // registers
    // ************************************************************
    logic [7:0] sp_mask_reg;
    logic [7:0] bp_mask_reg;
    logic [7:0] sp_limit_reg;
    logic [7:0] bp_limit_reg;
    logic [3:0] ctrl_reg;
    logic aw_hold_reg;
    logic w_hold_reg;
    logic [7:0] aw_addr_reg;
    logic [31:0] w_data_reg;
    logic [3:0] w_strb_reg;
    logic bvalid_reg;
    logic [1:0] bresp_reg;
    logic rvalid_reg;
    logic [1:0] rresp_reg;
    logic [31:0] rdata_reg;

    // each register owns one aligned word: byte address is four times its index
    function automatic logic reg_hit(input logic [7:0] addr, input logic [7:0] idx);
        return addr == {idx[5:0], 2'b00};
    endfunction

    assign s_axi_awready_out = !aw_hold_reg && !bvalid_reg;
    assign s_axi_wready_out = !w_hold_reg && !bvalid_reg;
    assign s_axi_arready_out = !rvalid_reg;
    wire aw_take = s_axi_awvalid_in && s_axi_awready_out;
    wire w_take = s_axi_wvalid_in && s_axi_wready_out;
    wire aw_have = aw_hold_reg || aw_take;
    wire w_have = w_hold_reg || w_take;
    wire wr_fire = aw_have && w_have;
    wire [7:0] wr_addr = aw_hold_reg ? aw_addr_reg : s_axi_awaddr_in;
    wire [31:0] wr_data = w_hold_reg ? w_data_reg : s_axi_wdata_in;
    wire [3:0] wr_strb = w_hold_reg ? w_strb_reg : s_axi_wstrb_in;
    wire wr_lane0 = wr_fire && wr_strb[0];
    wire [7:0] wr_byte = wr_data[7:0];
    wire wr_sp_mask = reg_hit(wr_addr, HPDPC_OFF_SP_MASK);
    wire wr_bp_mask = reg_hit(wr_addr, HPDPC_OFF_BP_MASK);
    wire wr_sp_lim = reg_hit(wr_addr, HPDPC_OFF_SP_LIMIT);
    wire wr_bp_lim = reg_hit(wr_addr, HPDPC_OFF_BP_LIMIT);
    wire wr_ctrl = reg_hit(wr_addr, HPDPC_OFF_CTRL);
    wire wr_status = reg_hit(wr_addr, HPDPC_OFF_STATUS);
    wire wr_mapped = wr_sp_mask || wr_bp_mask || wr_sp_lim || wr_bp_lim || wr_ctrl || wr_status;

    always_ff @(posedge clock_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            aw_hold_reg <= 1'b0;
            w_hold_reg <= 1'b0;
            aw_addr_reg <= 8'h00;
            w_data_reg <= 32'h00000000;
            w_strb_reg <= 4'h0;
            bvalid_reg <= 1'b0;
            bresp_reg <= HPDPC_RESP_OKAY;
        end
        else
        begin
            if (aw_take)
                aw_addr_reg <= s_axi_awaddr_in;
            if (w_take)
            begin
                w_data_reg <= s_axi_wdata_in;
                w_strb_reg <= s_axi_wstrb_in;
            end
            aw_hold_reg <= aw_have && !wr_fire;
            w_hold_reg <= w_have && !wr_fire;
            if (wr_fire)
            begin
                bvalid_reg <= 1'b1;
                bresp_reg <= wr_mapped ? HPDPC_RESP_OKAY : HPDPC_RESP_SLVERR;
            end
            else if (s_axi_bready_in)
                bvalid_reg <= 1'b0;
        end
    end

    always_ff @(posedge clock_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            sp_mask_reg <= HPDPC_RST_MASK;
            bp_mask_reg <= HPDPC_RST_MASK;
            sp_limit_reg <= HPDPC_RST_LIMIT;
            bp_limit_reg <= HPDPC_RST_LIMIT;
            ctrl_reg <= 4'h0;
        end
        else if (wr_lane0)
        begin
            if (wr_sp_mask)
                sp_mask_reg <= wr_byte & HPDPC_MASK_RSVD;
            if (wr_bp_mask)
                bp_mask_reg <= wr_byte & HPDPC_MASK_RSVD;
            if (wr_sp_lim)
                sp_limit_reg <= wr_byte;
            if (wr_bp_lim)
                bp_limit_reg <= wr_byte;
            if (wr_ctrl)
                ctrl_reg <= wr_byte[3:0];
        end
    end

    // ************************************************************
    // port disable and numbering
    // ************************************************************
    wire remap_on = ctrl_reg[HPDPC_CTRL_REMAP];
    wire self_pwr = ctrl_reg[HPDPC_CTRL_SELFPWR];
    wire [7:1] sp_off = ctrl_reg[HPDPC_CTRL_DEFCFG] ? strap_off : sp_mask_reg[7:1];
    wire [7:1] bp_off = ctrl_reg[HPDPC_CTRL_DEFCFG] ? strap_off : bp_mask_reg[7:1];
    wire [7:1] mode_off = self_pwr ? sp_off : bp_off;
    wire [7:1] eff_off = remap_on ? 7'h00 : mode_off;

    hpdpc_map_if map_bus ();
    assign map_bus.off_mask = eff_off;
    hpdpc_port_map u_map (
        .map(map_bus)
    );

    wire [7:0] limit_sel = self_pwr ? sp_limit_reg : bp_limit_reg;
    logic [7:1] disabled_reg;
    logic [2:0] count_reg;
    logic [20:0] number_reg;
    logic [7:0] limit_reg;
    logic [9:0] ma_reg;
    logic [20:0] number_next;
    always_comb
    begin
        number_next = 21'h000000;
        for (int i = 1; i <= HPDPC_PORTS; i++)
            number_next[(i-1)*3 +: 3] = map_bus.logical_num[i];
    end

    always_ff @(posedge clock_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            disabled_reg <= 7'h00;
            count_reg <= 3'h0;
            number_reg <= 21'h000000;
            limit_reg <= 8'h00;
            ma_reg <= 10'h000;
        end
        else
        begin
            disabled_reg <= eff_off;
            count_reg <= map_bus.enabled_count;
            number_reg <= number_next;
            limit_reg <= limit_sel;
            ma_reg <= 10'(limit_sel * HPDPC_MA_PER_UNIT);
        end
    end
    assign port_disabled_out = disabled_reg;
    assign port_count_out = count_reg;
    assign port_number_out = number_reg;
    assign current_limit_out = limit_reg;
    assign current_ma_out = ma_reg;
    assign remap_mode_out = ctrl_reg[HPDPC_CTRL_REMAP];
    assign compound_out = ctrl_reg[HPDPC_CTRL_COMPOUND];

    // ************************************************************
    // read channel
    // ************************************************************
    wire [7:0] rd_addr = s_axi_araddr_in;
    wire [31:0] status_word = {17'h00000, map_bus.enabled_count, eff_off, 1'b0, remap_on, 3'h0};
    wire rd_sp_mask = reg_hit(rd_addr, HPDPC_OFF_SP_MASK);
    wire rd_bp_mask = reg_hit(rd_addr, HPDPC_OFF_BP_MASK);
    wire rd_sp_lim = reg_hit(rd_addr, HPDPC_OFF_SP_LIMIT);
    wire rd_bp_lim = reg_hit(rd_addr, HPDPC_OFF_BP_LIMIT);
    wire rd_ctrl = reg_hit(rd_addr, HPDPC_OFF_CTRL);
    wire rd_status = reg_hit(rd_addr, HPDPC_OFF_STATUS);
    wire rd_mapped = rd_sp_mask || rd_bp_mask || rd_sp_lim || rd_bp_lim || rd_ctrl || rd_status;
    wire [31:0] rd_word =
        rd_sp_mask ? {24'h000000, sp_mask_reg} :
        rd_bp_mask ? {24'h000000, bp_mask_reg} :
        rd_sp_lim ? {24'h000000, sp_limit_reg} :
        rd_bp_lim ? {24'h000000, bp_limit_reg} :
        rd_ctrl ? {28'h0000000, ctrl_reg} :
        rd_status ? status_word : 32'h00000000;
    wire rd_take = s_axi_arvalid_in && s_axi_arready_out;

    always_ff @(posedge clock_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            rvalid_reg <= 1'b0;
            rresp_reg <= HPDPC_RESP_OKAY;
            rdata_reg <= 32'h00000000;
        end
        else if (rd_take)
        begin
            rvalid_reg <= 1'b1;
            rresp_reg <= rd_mapped ? HPDPC_RESP_OKAY : HPDPC_RESP_SLVERR;
            rdata_reg <= rd_word;
        end
        else if (s_axi_rready_in)
            rvalid_reg <= 1'b0;
    end
    assign s_axi_bvalid_out = bvalid_reg;
    assign s_axi_bresp_out = bresp_reg;
    assign s_axi_rvalid_out = rvalid_reg;
    assign s_axi_rresp_out = rresp_reg;
    assign s_axi_rdata_out = rdata_reg;

    // ************************************************************
    // checks
    // ************************************************************
    a_mask_bit_zero: assert property (@(posedge clock_in) disable iff (!arst_n_in)
        !sp_mask_reg[0] && !bp_mask_reg[0]) else $error("mask bit zero set");
    a_remap_no_disable: assert property (@(posedge clock_in) disable iff (!arst_n_in)
        remap_on |=> port_disabled_out == 7'h00) else $error("port disabled in remap mode");
    a_sp_mask_apply: assert property (@(posedge clock_in) disable iff (!arst_n_in)
        (!remap_on && self_pwr && !ctrl_reg[HPDPC_CTRL_DEFCFG]) |=> port_disabled_out == $past(sp_mask_reg[7:1]))
        else $error("self-powered mask not applied");
    a_bp_mask_apply: assert property (@(posedge clock_in) disable iff (!arst_n_in)
        (!remap_on && !self_pwr && !ctrl_reg[HPDPC_CTRL_DEFCFG]) |=> port_disabled_out == $past(bp_mask_reg[7:1]))
        else $error("bus-powered mask not applied");
    a_strap_apply: assert property (@(posedge clock_in) disable iff (!arst_n_in)
        (!remap_on && ctrl_reg[HPDPC_CTRL_DEFCFG]) |=> port_disabled_out == $past(strap_off))
        else $error("strap disables not applied");
    a_count_match: assert property (@(posedge clock_in) disable iff (!arst_n_in)
        arst_n_in |=> port_count_out == 3'(HPDPC_PORTS - $countones($past(eff_off))))
        else $error("enabled port count wrong");
    a_limit_ma: assert property (@(posedge clock_in) disable iff (!arst_n_in)
        current_ma_out == {1'b0, current_limit_out, 1'b0}) else $error("mA scaling wrong");
    a_bresp_once: assert property (@(posedge clock_in) disable iff (!arst_n_in)
        wr_fire |=> s_axi_bvalid_out) else $error("write response missing");
    a_rd_answer: assert property (@(posedge clock_in) disable iff (!arst_n_in)
        rd_take |=> s_axi_rvalid_out && s_axi_rdata_out == $past(rd_word)) else $error("read answer wrong");
    a_remap_count: assert property (@(posedge clock_in) disable iff (!arst_n_in)
        remap_on
        |=> port_count_out == 3'(HPDPC_PORTS))
        else $error("remap mode hides ports");
    a_sp_limit_sel: assert property (@(posedge clock_in) disable iff (!arst_n_in)
        arst_n_in && self_pwr
        |=> current_limit_out == $past(sp_limit_reg))
        else $error("self-powered limit not reported");
    a_bp_limit_sel: assert property (@(posedge clock_in) disable iff (!arst_n_in)
        arst_n_in && !self_pwr
        |=> current_limit_out == $past(bp_limit_reg))
        else $error("bus-powered limit not reported");
    a_ctrl_write: assert property (@(posedge clock_in) disable iff (!arst_n_in)
        wr_lane0 && wr_ctrl
        |=> ctrl_reg == $past(wr_byte[3:0]))
        else $error("control write lost");
    a_regs_steady: assert property (@(posedge clock_in) disable iff (!arst_n_in)
        !wr_lane0
        |=> $stable(sp_mask_reg) && $stable(bp_mask_reg) && $stable(sp_limit_reg) && $stable(bp_limit_reg))
        else $error("register changed without a write");

    // ************************************************************
    // bus checks
    // ************************************************************
    a_wr_refused: assert property (@(posedge clock_in) disable iff (!arst_n_in)
        s_axi_bvalid_out
        |-> !s_axi_awready_out && !s_axi_wready_out)
        else $error("write offered while response pending");
    a_rd_refused: assert property (@(posedge clock_in) disable iff (!arst_n_in)
        s_axi_rvalid_out
        |-> !s_axi_arready_out)
        else $error("read offered while data pending");
    a_wr_okay: assert property (@(posedge clock_in) disable iff (!arst_n_in)
        wr_fire && wr_mapped
        |=> s_axi_bresp_out == HPDPC_RESP_OKAY)
        else $error("mapped write refused");
    a_wr_unmapped: assert property (@(posedge clock_in) disable iff (!arst_n_in)
        wr_fire && !wr_mapped
        |=> s_axi_bresp_out == HPDPC_RESP_SLVERR)
        else $error("unmapped write accepted");
    a_rd_okay: assert property (@(posedge clock_in) disable iff (!arst_n_in)
        rd_take && rd_mapped
        |=> s_axi_rresp_out == HPDPC_RESP_OKAY)
        else $error("mapped read refused");
    a_rd_unmapped: assert property (@(posedge clock_in) disable iff (!arst_n_in)
        rd_take && !rd_mapped
        |=> s_axi_rresp_out == HPDPC_RESP_SLVERR && s_axi_rdata_out == 32'h00000000)
        else $error("unmapped read accepted");

    // ************************************************************
    // per-port numbering checks
    // ************************************************************
    for (genvar p = 1; p <= HPDPC_PORTS; p++)
    begin : g_port_chk
        a_off_unnumbered: assert property (@(posedge clock_in) disable iff (!arst_n_in)
            port_disabled_out[p]
            |-> port_number_out[(p-1)*3 +: 3] == 3'h0)
            else $error("disabled port given a number");
        a_on_numbered: assert property (@(posedge clock_in) disable iff (!arst_n_in)
            $past(arst_n_in) && !port_disabled_out[p]
            |-> port_number_out[(p-1)*3 +: 3] != 3'h0 && port_number_out[(p-1)*3 +: 3] <= port_count_out)
            else $error("enabled port number out of range");
    end
endmodule
`default_nettype wire

// >>> tb/hpdpc_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module hpdpc_host_model
    import hpdpc_pkg::*;
(
    input wire logic [7:1] port_disabled_in, // ports withheld by the hub
    input wire logic [2:0] port_count_in, // reported port count
    input wire logic [20:0] port_number_in, // logical number per physical port
    output logic [7:1] offered_out, // ports the host may enable
    output logic enum_ok_out // numbers 1..count each on one enabled port
);
    logic [7:0] seen;
    // ***************
    // enumeration view
    // ***************
    always_comb
    begin
        seen = 8'h00;
        enum_ok_out = 1'b1;
        for (int i = 1; i <= HPDPC_PORTS; i++)
        begin
            offered_out[i] = (port_number_in[3*(i-1)+:3] != 3'h0);
            if (offered_out[i] == port_disabled_in[i] || port_number_in[3*(i-1)+:3] > port_count_in)
                enum_ok_out = 1'b0;
            if (offered_out[i] && seen[port_number_in[3*(i-1)+:3]])
                enum_ok_out = 1'b0;
            if (offered_out[i])
                seen[port_number_in[3*(i-1)+:3]] = 1'b1;
        end
        if ($countones(seen) != port_count_in)
            enum_ok_out = 1'b0;
    end
endmodule
`default_nettype wire

// >>> tb/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench
    import hpdpc_pkg::*;
;
    logic clock_in, arst_n_in, awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
    logic [7:0] awaddr, araddr, current_limit_out;
    logic [31:0] wdata, rdata;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp;
    logic [7:1] strap_p, strap_m, port_disabled_out, offered;
    logic [2:0] port_count_out;
    logic [20:0] port_number_out;
    logic remap_mode_out, compound_out, enum_ok;
    logic [9:0] current_ma_out;
    int errors, check_count;
    logic [7:0] mask_pats [6] = '{8'h02, 8'h54, 8'haa, 8'hfe, 8'h81, 8'h26};

    hpdpc_top uut (.clock_in(clock_in), .arst_n_in(arst_n_in), .s_axi_awaddr_in(awaddr),
        .s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready), .s_axi_wdata_in(wdata),
        .s_axi_wstrb_in(wstrb), .s_axi_wvalid_in(wvalid), .s_axi_wready_out(wready),
        .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bvalid), .s_axi_bready_in(bready),
        .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid), .s_axi_arready_out(arready),
        .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp), .s_axi_rvalid_out(rvalid),
        .s_axi_rready_in(rready), .port_off_strap_plus_in(strap_p), .port_off_strap_minus_in(strap_m),
        .port_disabled_out(port_disabled_out), .port_count_out(port_count_out),
        .port_number_out(port_number_out), .remap_mode_out(remap_mode_out), .compound_out(compound_out),
        .current_limit_out(current_limit_out), .current_ma_out(current_ma_out));

    hpdpc_host_model host (.port_disabled_in(port_disabled_out), .port_count_in(port_count_out),
        .port_number_in(port_number_out), .offered_out(offered), .enum_ok_out(enum_ok));

    always #25 clock_in = ~clock_in;

    // ***************
    // helpers
    // ***************
    function automatic logic [7:0] ad(input logic [7:0] idx);
        return {idx[5:0], 2'b00};
    endfunction

    function automatic logic [20:0] exp_num(input logic [7:1] off);
        logic [20:0] r;
        logic [2:0] k;
        r = 21'h000000;
        k = 3'h0;
        for (int i = 1; i <= 7; i++)
            if (!off[i])
            begin
                k = k + 3'h1;
                r[3*(i-1)+:3] = k;
            end
        return r;
    endfunction

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            errors++;
            $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic axi_wr(input logic [7:0] idx, input logic [7:0] d, input logic [1:0] er);
        awaddr <= ad(idx);
        wdata <= {24'h000000, d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do
        begin
            @(posedge clock_in);
            if (awvalid && awready)
                awvalid <= 1'b0;
            if (wvalid && wready)
                wvalid <= 1'b0;
        end
        while (bvalid !== 1'b1);
        chk({30'h0, bresp}, {30'h0, er});
        bready <= 1'b0;
        @(posedge clock_in);
    endtask

    task automatic axi_rd(input logic [7:0] idx, input logic [31:0] d, input logic [1:0] er);
        araddr <= ad(idx);
        arvalid <= 1'b1;
        rready <= 1'b1;
        do
        begin
            @(posedge clock_in);
            if (arvalid && arready)
                arvalid <= 1'b0;
        end
        while (rvalid !== 1'b1);
        chk(rdata, d);
        chk({30'h0, rresp}, {30'h0, er});
        rready <= 1'b0;
        @(posedge clock_in);
    endtask

    task automatic chk_ports(input logic [7:1] off);
        repeat (3) @(posedge clock_in);
        chk({25'h0, port_disabled_out}, {25'h0, off});
        chk({29'h0, port_count_out}, 32'(7 - $countones(off)));
        chk({11'h0, port_number_out}, {11'h0, exp_num(off)});
        chk({25'h0, offered}, {25'h0, ~off});
        chk({31'h0, enum_ok}, 32'h1);
    endtask

    task automatic complete_run();
        $display("checks %0d mismatches %0d", check_count, errors);
        if (errors == 0 && check_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // ***************
    // tests
    // ***************
    initial
    begin
        errors = 0;
        check_count = 0;
        clock_in = 1'b0;
        arst_n_in = 1'b0;
        {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
        awaddr = 8'h00;
        araddr = 8'h00;
        wdata = 32'h00000000;
        wstrb = 4'h1;
        strap_p = 7'h00;
        strap_m = 7'h00;
        repeat (10) @(posedge clock_in);
        arst_n_in <= 1'b1;
        repeat (2) @(posedge clock_in);
        chk({24'h0, current_limit_out}, 32'h32);
        chk({22'h0, current_ma_out}, 32'(50 * HPDPC_MA_PER_UNIT));
        axi_rd(HPDPC_OFF_SP_MASK, 8'h00, HPDPC_RESP_OKAY);
        axi_rd(HPDPC_OFF_BP_MASK, 8'h00, HPDPC_RESP_OKAY);
        axi_rd(HPDPC_OFF_SP_LIMIT, 8'h32, HPDPC_RESP_OKAY);
        axi_rd(HPDPC_OFF_BP_LIMIT, 8'h32, HPDPC_RESP_OKAY);
        axi_rd(8'h3f, 8'h00, HPDPC_RESP_SLVERR);
        axi_wr(8'h3f, 8'h5a, HPDPC_RESP_SLVERR);
        $display("test reset finished");
        for (int i = 0; i < 6; i++)
        begin
            axi_wr(HPDPC_OFF_CTRL, 8'h08, HPDPC_RESP_OKAY);
            axi_wr(HPDPC_OFF_SP_MASK, mask_pats[i], HPDPC_RESP_OKAY);
            axi_wr(HPDPC_OFF_BP_MASK, ~mask_pats[i], HPDPC_RESP_OKAY);
            chk_ports(mask_pats[i][7:1]);
            axi_rd(HPDPC_OFF_SP_MASK, mask_pats[i] & HPDPC_MASK_RSVD, HPDPC_RESP_OKAY);
            axi_rd(HPDPC_OFF_BP_MASK, ~mask_pats[i] & HPDPC_MASK_RSVD, HPDPC_RESP_OKAY);
            axi_wr(HPDPC_OFF_CTRL, 8'h00, HPDPC_RESP_OKAY);
            chk_ports(~mask_pats[i][7:1]);
        end
        $display("test masks finished");
        axi_wr(HPDPC_OFF_CTRL, 8'h01, HPDPC_RESP_OKAY);
        chk_ports(7'h00);
        chk({31'h0, remap_mode_out}, 32'h1);
        axi_rd(HPDPC_OFF_STATUS, {17'h0, 3'h7, 7'h00, 1'b0, 1'b1, 3'h0}, HPDPC_RESP_OKAY);
        axi_wr(HPDPC_OFF_CTRL, 8'h02, HPDPC_RESP_OKAY);
        repeat (2) @(posedge clock_in);
        chk({31'h0, compound_out}, 32'h1);
        chk({31'h0, remap_mode_out}, 32'h0);
        $display("test modes finished");
        strap_p <= 7'h05;
        strap_m <= 7'h40;
        axi_wr(HPDPC_OFF_CTRL, 8'h04, HPDPC_RESP_OKAY);
        repeat (2) @(posedge clock_in);
        chk_ports(7'h45);
        axi_rd(HPDPC_OFF_STATUS, {17'h0, 3'h4, 7'h45, 5'h00}, HPDPC_RESP_OKAY);
        axi_wr(HPDPC_OFF_STATUS, 8'hff, HPDPC_RESP_OKAY);
        axi_rd(HPDPC_OFF_CTRL, 8'h04, HPDPC_RESP_OKAY);
        $display("test straps finished");
        axi_wr(HPDPC_OFF_SP_LIMIT, 8'h30, HPDPC_RESP_OKAY);
        axi_wr(HPDPC_OFF_BP_LIMIT, 8'hff, HPDPC_RESP_OKAY);
        axi_wr(HPDPC_OFF_CTRL, 8'h08, HPDPC_RESP_OKAY);
        repeat (2) @(posedge clock_in);
        chk({24'h0, current_limit_out}, 32'h30);
        chk({22'h0, current_ma_out}, 32'(8'h30 * HPDPC_MA_PER_UNIT));
        axi_wr(HPDPC_OFF_CTRL, 8'h00, HPDPC_RESP_OKAY);
        repeat (2) @(posedge clock_in);
        chk({24'h0, current_limit_out}, 32'hff);
        chk({22'h0, current_ma_out}, 32'(8'hff * HPDPC_MA_PER_UNIT));
        $display("test limits finished");
        complete_run();
    end

    initial
    begin
        repeat (5000) @(posedge clock_in);
        errors++;
        $display("watchdog expired");
        complete_run();
    end
endmodule
`default_nettype wire
